// ===== fpss_ctrl.sv
// host controller that drives a parallel flash through its pins
// assumes dq is an external two-way bus resolved by the testbench
`timescale 1ns/1ns
`include "fpss_map.svh"
module fpss_ctrl #(
  parameter int SETUP_CYC = `FPSS_SETUP_CYC,
  parameter int PULSE_CYC = `FPSS_PULSE_CYC,
  parameter int READ_CYC  = `FPSS_READ_CYC
) (
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire logic [3:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [31:0]        reg_rdata,
  output fpss_pkg::fpss_pins_t    flash,
  input  wire logic [15:0]        dq_in
);
  initial begin
    if (SETUP_CYC < 1 || PULSE_CYC < 1 || READ_CYC < 1 || READ_CYC > 255 ||
        SETUP_CYC > 255 || PULSE_CYC > 255)
      $error("fpss_ctrl: timing counts must be 1..255");
  end

  fpss_pkg::fpss_state_t st_q, st_d;
  fpss_pkg::fpss_pins_t  pin_q, pin_d;
  fpss_pkg::fpss_cyc_t   cyc_q, cyc_d;
  logic [7:0]  cnt_q, cnt_d;
  logic [1:0]  seq_q, seq_d;      // requested command sequence
  logic [1:0]  step_q, step_d;    // cycle within a sequence
  logic        busy_q, busy_d;
  logic        tmpunp_q, tmpunp_d;
  logic        hva9_q, hva9_d;
  logic        wehi_q, wehi_d;
  logic        secmode_q, secmode_d;
  logic [15:0] rdata_q, rdata_d;
  logic [15:0] dq_s1_q, dq_s2_q;  // pin synchroniser
  logic [31:0] rd_q, rd_d;

  // sequence cycle table: unlock, unlock, command, exit; reset is one cycle
  function automatic fpss_pkg::fpss_cyc_t seq_cycle(input logic [1:0] seq,
                                                    input logic [1:0] step);
    fpss_pkg::fpss_cyc_t c;
    c.write = 1'b1;
    c.addr  = (step == 2'h1) ? `FPSS_UNLOCK2_A : `FPSS_UNLOCK1_A;
    c.data  = (step == 2'h0) ? `FPSS_UNLOCK1_D : `FPSS_UNLOCK2_D;
    if (step == 2'h2)
      c.data = (seq == `FPSS_SEQ_ENTER) ? `FPSS_ENTER_D : `FPSS_AUTOSEL_D;
    if (step == 2'h3) begin
      c.addr = 22'h000000;
      c.data = `FPSS_EXIT_D;
    end
    if (seq == `FPSS_SEQ_RESET)
      c.data = `FPSS_RESET_D; // single cycle abort back to array read, see R20
    return c;
  endfunction

  function automatic logic [1:0] seq_last(input logic [1:0] seq);
    return (seq == `FPSS_SEQ_ENTER) ? 2'h2 :
           (seq == `FPSS_SEQ_EXIT) ? 2'h3 : 2'h0;
  endfunction

  // two flops before anything reads the data pins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
    end else begin
      dq_s1_q <= dq_in;
      dq_s2_q <= dq_s1_q;
    end
  end

  // register port and bus-cycle sequencer
  always_comb begin
    st_d      = st_q;
    cyc_d     = cyc_q;
    cnt_d     = cnt_q;
    seq_d     = seq_q;
    step_d    = step_q;
    busy_d    = busy_q;
    tmpunp_d  = tmpunp_q;
    hva9_d    = hva9_q;
    wehi_d    = wehi_q;
    secmode_d = secmode_q;
    rdata_d   = rdata_q;
    rd_d      = 32'h00000000;
    if (reg_wr && !busy_q) begin
      unique case (reg_addr)
        `FPSS_REG_ADDR:  cyc_d.addr = reg_wdata[21:0];
        `FPSS_REG_WDATA: cyc_d.data = reg_wdata[15:0];
        `FPSS_REG_CTRL: begin
          tmpunp_d = reg_wdata[`FPSS_CTRL_TMPUNP]; // see R1 see R2 see R21
          hva9_d   = reg_wdata[`FPSS_CTRL_HVA9];
          wehi_d   = reg_wdata[`FPSS_CTRL_WEHI];
          seq_d    = reg_wdata[`FPSS_CTRL_SEQ +: 2];
          if (reg_wdata[`FPSS_CTRL_GO]) begin
            busy_d = 1'b1;
            step_d = 2'h0;
            st_d   = fpss_pkg::FPSS_SETUP;
            cnt_d  = 8'(SETUP_CYC);
            if (reg_wdata[`FPSS_CTRL_SEQ +: 2] != 2'h0)
              cyc_d = seq_cycle(reg_wdata[`FPSS_CTRL_SEQ +: 2], 2'h0); // see R6 see R13
            else
              cyc_d.write = reg_wdata[`FPSS_CTRL_WRITE];
          end
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `FPSS_REG_ADDR:   rd_d = {10'h000, cyc_q.addr};
        `FPSS_REG_WDATA:  rd_d = {16'h0000, cyc_q.data};
        `FPSS_REG_STATUS: rd_d = {27'h0000000, rdata_q[`FPSS_LOCK_BIT], secmode_q,
                                  hva9_q, tmpunp_q, busy_q}; // see R8
        `FPSS_REG_RDATA:  rd_d = {16'h0000, rdata_q};
        `FPSS_REG_CTRL:   rd_d = {25'h0000000, seq_q, wehi_q, hva9_q, tmpunp_q,
                                  1'b0, busy_q};
        default:          rd_d = 32'h00000000;
      endcase
    end
    if (cnt_q != 8'h00)
      cnt_d = cnt_q - 8'h01;
    unique case (st_q)
      fpss_pkg::FPSS_IDLE: ;
      fpss_pkg::FPSS_SETUP:
        if (cnt_q <= 8'h01) begin
          st_d  = cyc_q.write ? fpss_pkg::FPSS_PULSE : fpss_pkg::FPSS_READ;
          cnt_d = cyc_q.write ? 8'(PULSE_CYC) : 8'(READ_CYC);
        end
      fpss_pkg::FPSS_PULSE:
        if (cnt_q <= 8'h01) begin // we pulse far above glitch width, see R16
          st_d  = fpss_pkg::FPSS_HOLD;
          cnt_d = 8'(SETUP_CYC);
        end
      fpss_pkg::FPSS_READ:
        if (cnt_q <= 8'h01) begin
          rdata_d = dq_s2_q; // see R3 see R4 see R11
          st_d    = fpss_pkg::FPSS_HOLD;
          cnt_d   = 8'(SETUP_CYC);
        end
      fpss_pkg::FPSS_HOLD:
        if (cnt_q <= 8'h01) begin
          if (seq_q != 2'h0 && step_q != seq_last(seq_q)) begin
            step_d = step_q + 2'h1; // complete ordered sequence only, see R6
            cyc_d  = seq_cycle(seq_q, step_q + 2'h1);
            st_d   = fpss_pkg::FPSS_SETUP;
            cnt_d  = 8'(SETUP_CYC);
          end else begin
            if (seq_q == `FPSS_SEQ_ENTER)
              secmode_d = 1'b1; // see R7 see R9
            else if (seq_q == `FPSS_SEQ_EXIT)
              secmode_d = 1'b0; // only exit or a controller reset leaves secured mode, see R14 see R9
            busy_d = 1'b0;
            st_d   = fpss_pkg::FPSS_IDLE;
          end
        end
      default: st_d = fpss_pkg::FPSS_IDLE;
    endcase
  end

  // pin values follow the state; writes only as ce=we=low, oe=high
  always_comb begin
    pin_d          = pin_q;
    pin_d.rst_n    = 1'b1;
    pin_d.hv_reset = tmpunp_q;              // see R1 see R21
    pin_d.hv_a9    = hva9_q;                // see R3 see R4
    pin_d.addr     = cyc_q.addr;            // stable before we falls, set one cycle after cyc_q.addr changes, see R19
    pin_d.dq_out   = cyc_q.data;
    pin_d.ce_n     = (st_q == fpss_pkg::FPSS_IDLE);
    pin_d.oe_n     = !(st_q == fpss_pkg::FPSS_READ ||
                       (st_q == fpss_pkg::FPSS_SETUP && !cyc_q.write));
    pin_d.we_n     = !(st_q == fpss_pkg::FPSS_PULSE) &&
                     !(st_q != fpss_pkg::FPSS_IDLE && !cyc_q.write && !wehi_q); // see R17
    if (!cyc_q.write)
      pin_d.we_n   = 1'b1;
    pin_d.dq_oe_n  = !(cyc_q.write && st_q != fpss_pkg::FPSS_IDLE);
  end

  // registers only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= fpss_pkg::FPSS_IDLE;
      cyc_q     <= '0;
      cnt_q     <= 8'h00;
      seq_q     <= 2'h0;
      step_q    <= 2'h0;
      busy_q    <= 1'b0;
      tmpunp_q  <= 1'b0;
      hva9_q    <= 1'b0;
      wehi_q    <= 1'b0;
      secmode_q <= 1'b0;           // flash reset leaves secured mode, see R10
      rdata_q   <= 16'h0000;
      rd_q      <= 32'h00000000;
      pin_q     <= {1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 22'h000000, 16'h0000, 1'b1};
    end else begin
      st_q      <= st_d;
      cyc_q     <= cyc_d;
      cnt_q     <= cnt_d;
      seq_q     <= seq_d;
      step_q    <= step_d;
      busy_q    <= busy_d;
      tmpunp_q  <= tmpunp_d;
      hva9_q    <= hva9_d;
      wehi_q    <= wehi_d;
      secmode_q <= secmode_d;
      rdata_q   <= rdata_d;
      rd_q      <= rd_d;
      pin_q     <= pin_d;
    end
  end

  assign reg_rdata = rd_q;
  assign flash     = pin_q;

  // write strobe never low unless ce low and oe high
  property p_write_qual;
    @(posedge mclk) disable iff (!rst_n)
      !flash.we_n |-> (!flash.ce_n && flash.oe_n);
  endproperty
  a_write_qual: assert property (p_write_qual) else $error("we low outside write"); // see R17

  // write pulse stays low for at least two cycles
  sequence s_we_pulse;
    !flash.we_n [*2];
  endsequence

  property p_pulse_width;
    @(posedge mclk) disable iff (!rst_n)
      $fell(flash.we_n) |-> s_we_pulse;
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("we pulse too short"); // see R16

  // address stable across the write pulse
  property p_addr_stable;
    @(posedge mclk) disable iff (!rst_n)
      !flash.we_n && !$past(flash.we_n) |-> $stable(flash.addr);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("addr moved in pulse"); // see R19

  // secured mode rises only after the enter sequence
  property p_enter_sets;
    @(posedge mclk) disable iff (!rst_n)
      $rose(secmode_q) |-> $past(seq_q) == `FPSS_SEQ_ENTER;
  endproperty
  a_enter_sets: assert property (p_enter_sets) else $error("secured mode w/o enter"); // see R9

  // outside controller reset only the exit sequence clears secured mode; a reset command does not
  property p_exit_clears;
    @(posedge mclk) disable iff (!rst_n)
      $fell(secmode_q) |-> $past(seq_q) == `FPSS_SEQ_EXIT;
  endproperty
  a_exit_clears: assert property (p_exit_clears) else $error("secured mode lost"); // see R14

  // high voltage reset level follows control bit
  property p_hv_reset;
    @(posedge mclk) disable iff (!rst_n)
      ##1 flash.hv_reset == $past(tmpunp_q);
  endproperty
  a_hv_reset: assert property (p_hv_reset) else $error("hv reset mismatch"); // see R1

  // identifier read drives no data onto the bus
  property p_read_noout;
    @(posedge mclk) disable iff (!rst_n)
      !flash.oe_n |-> flash.dq_oe_n;
  endproperty
  a_read_noout: assert property (p_read_noout) else $error("bus contention"); // see R3

  // busy clears within bounded time
  property p_busy_done;
    @(posedge mclk) disable iff (!rst_n)
      $rose(busy_q) |-> ##[1:1000] !busy_q;
  endproperty
  a_busy_done: assert property (p_busy_done) else $error("sequence hung"); // see R6
endmodule

// ===== fpss_map.svh
// constants of the flash protect / secured sector host controller
// assumes a 25 MHz mclk and a flash wired to the controller's pins
// Operation
// R1: while reset pin sits at high voltage, protected groups accept program and erase.
// R2: removing high voltage from reset pin restores earlier protection.
// R3: id read: addr_bit9 high voltage, ce oe a6 a1 low; a0 picks maker/part.
// R4: protect verify: a9 high voltage, we a1 high, ce oe a6 a0 low; 01H/00H.
// R5: power-up resets the command machine to array read.
// R6: array changes only after a complete correct command sequence.
// R7: 128-word secured region read at first_sector addresses after enter sequence.
// R8: lock_indicator_bit reads 1 factory-locked, 0 customer-lockable.
// R9: secured mode disables boot sectors until exit sequence or power loss.
// R10: power-up or hardware reset leaves secured mode.
// R11: factory parts hold 8-word serial number at lowest locations; none modifiable.
// R12: once the secured region is protected it can never change.
// R13: host locks region: three-cycle enter, then in-system protect algorithm.
// R14: host writes exit sequence before touching the rest of the array.
// R15: below supply_lockout_threshold all writes are ignored and device held reset.
// R16: pulses shorter than 5ns on ce or we start no write.
// R17: write only with ce and we low and oe high.
// R18: writes held low at power-up give no command on we rising edge.
// R19: address latched on later falling edge of we or ce.
// R20: wrong values or order return device to array read.
// R21: each high-voltage pin condition is a separate qualifier.
// R22: per-group protect flags plus secured lock flag gate program and erase.
`ifndef FPSS_MAP_SVH
`define FPSS_MAP_SVH
`define FPSS_REG_CTRL     4'h0
`define FPSS_REG_ADDR     4'h1
`define FPSS_REG_WDATA    4'h2
`define FPSS_REG_STATUS   4'h3
`define FPSS_REG_RDATA    4'h4
`define FPSS_CLK_MHZ      25
`define FPSS_SETUP_NS     40
`define FPSS_PULSE_NS     60
`define FPSS_READ_NS      100
`define FPSS_SETUP_CYC    ((`FPSS_SETUP_NS*`FPSS_CLK_MHZ+999)/1000)
`define FPSS_PULSE_CYC    ((`FPSS_PULSE_NS*`FPSS_CLK_MHZ+999)/1000)
`define FPSS_READ_CYC     ((`FPSS_READ_NS*`FPSS_CLK_MHZ+999)/1000)
`define FPSS_UNLOCK1_A    22'h000555
`define FPSS_UNLOCK2_A    22'h0002AA
`define FPSS_UNLOCK1_D    16'h00AA
`define FPSS_UNLOCK2_D    16'h0055
`define FPSS_ENTER_D      16'h0088
`define FPSS_AUTOSEL_D    16'h0090
`define FPSS_EXIT_D       16'h0000
`define FPSS_RESET_D      16'h00F0
`define FPSS_ID_ADDR      22'h000000
`define FPSS_VERIFY_ADDR  22'h000002
`define FPSS_SECTOR_LSB   16
`define FPSS_LOCK_BIT     7
`define FPSS_CTRL_GO      0
`define FPSS_CTRL_WRITE   1
`define FPSS_CTRL_TMPUNP  2
`define FPSS_CTRL_HVA9    3
`define FPSS_CTRL_WEHI    4
`define FPSS_CTRL_SEQ     5
`define FPSS_SEQ_ENTER    2'h1
`define FPSS_SEQ_EXIT     2'h2
`define FPSS_SEQ_RESET    2'h3
`endif

// ===== fpss_pkg.sv
// types of the flash protect / secured sector host controller
// assumes fpss_map.svh gives the numbers
package fpss_pkg;
  typedef enum logic [2:0] {FPSS_IDLE, FPSS_SETUP, FPSS_PULSE, FPSS_HOLD,
                            FPSS_READ} fpss_state_t;
  // one flash bus cycle as the sequencer sees it
  typedef struct packed {
    logic        write;
    logic [21:0] addr;
    logic [15:0] data;
  } fpss_cyc_t;
  // pins toward the flash
  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        rst_n;
    logic        hv_reset;
    logic        hv_a9;
    logic [21:0] addr;
    logic [15:0] dq_out;
    logic        dq_oe_n;
  } fpss_pins_t;
endpackage

// ===== fpss_flash_model.sv
// behavioural flash: command steps, id and verify reads, secured region
// assumes pins come from the controller and dq is resolved outside
`timescale 1ns/1ns
module fpss_flash_model #(
  parameter logic [15:0] MAKER    = 16'h00A1, // arbitrary value
  parameter logic [15:0] PART     = 16'h00B2, // arbitrary value
  parameter logic [63:0] PROT     = 64'h4,
  parameter logic        LOCK_IND = 1'b1
) (
  input  fpss_pkg::fpss_pins_t pins,
  output logic [15:0]          dq,
  output logic                 drv
);
  logic [21:0] la;
  logic [7:0]  d;
  logic [1:0]  st;
  logic        sec;
  int          bad;
  logic        armed;
  logic        prot_hit;
  time         t_fall;
  // power-up lands in array read, normal array
  initial begin
    st = 2'h0;
    sec = 1'b0;
    bad = 0;
    armed = 1'b0;
    t_fall = 0;
  end
  // commands count only once ce_n has been seen high after power-up
  always @(posedge pins.ce_n) begin
    armed = 1'b1;
  end
  // glitch filter: a we_n low shorter than 5ns starts no write
  always @(negedge pins.we_n) begin
    t_fall = $time;
  end
  // program/erase gate of the addressed group; high voltage on reset lifts it
  assign prot_hit = PROT[pins.addr[21:16]] && !pins.hv_reset;
  // address taken when the later of ce_n / we_n falls
  always @(negedge pins.we_n or negedge pins.ce_n) begin
    if (!pins.we_n && !pins.ce_n)
      la = pins.addr;
  end
  // a write while oe_n is low is a host fault
  always @(negedge pins.we_n) begin
    if (!pins.ce_n && !pins.oe_n)
      bad++;
  end
  // data taken on we_n rise; any wrong step drops back to read
  always @(posedge pins.we_n or negedge pins.rst_n) begin
    d = pins.dq_out[7:0];
    if (!pins.rst_n) begin
      st <= 2'h0;
      sec <= 1'b0;
    end else if (!pins.ce_n && pins.oe_n && armed && ($time - t_fall) >= 5) begin
      if (d == 8'hF0)
        st <= 2'h0;
      else if (st == 2'h0 && la[11:0] == 12'h555 && d == 8'hAA)
        st <= 2'h1;
      else if (st == 2'h1 && la[11:0] == 12'h2AA && d == 8'h55)
        st <= 2'h2;
      else if (st == 2'h2 && la[11:0] == 12'h555 && d == 8'h88) begin
        sec <= 1'b1;
        st <= 2'h0;
      end else if (st == 2'h2 && la[11:0] == 12'h555 && d == 8'h90)
        st <= 2'h3;
      else if (st == 2'h3 && d == 8'h00) begin
        sec <= 1'b0;
        st <= 2'h0;
      end else
        st <= 2'h0;
    end
  end
  // async read path; drives only while selected and gated
  assign drv = !pins.ce_n && !pins.oe_n;
  always_comb begin
    if (pins.hv_a9 && !pins.addr[6] && pins.addr[1])
      dq = {15'h0000, PROT[pins.addr[21:16]]};
    else if (pins.hv_a9 && !pins.addr[6])
      dq = pins.addr[0] ? PART : MAKER;
    else if (sec && pins.addr[21:7] == 15'h0000)
      dq = {8'h00, LOCK_IND, pins.addr[6:0]}; // fixed contents
    else
      dq = ~pins.addr[15:0];
  end
endmodule

// ===== fpss_ctrl_tb_top.sv
// testbench of the flash host controller against a behavioural flash
// assumes fpss_pkg, fpss_ctrl and fpss_flash_model are compiled first
`timescale 1ns/1ns
module fpss_ctrl_tb_top;
  logic        mclk;
  logic        rst_n;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [15:0] dq_in;
  logic [15:0] mdq;
  logic        mdrv;
  logic [31:0] v;
  int          errors;
  int          checked;
  int          cyc;
  fpss_pkg::fpss_pins_t flash;
  fpss_ctrl dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .flash(flash), .dq_in(dq_in));
  fpss_flash_model m (.pins(flash), .dq(mdq), .drv(mdrv));
  // undriven bus wobbles each cycle so stale data never matches
  assign dq_in = !flash.dq_oe_n ? flash.dq_out : mdrv ? mdq : {8'hA5, {8{mclk}}};
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic close_out();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ceiling far above the few hundred cycles the tests need
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end
  task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", w, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // one flash operation, then poll busy under a bound
  task automatic op(input logic [21:0] a, input logic [15:0] d, input logic [7:0] c);
    int n;
    wr(4'h1, {10'h000, a});
    wr(4'h2, {16'h0000, d});
    wr(4'h0, {24'h000000, c});
    repeat (2) @(posedge mclk);
    for (n = 0; n < 200; n++) begin
      rd(4'h3, v);
      if (v[0] === 1'b0)
        break;
    end
    check("busy", {31'h0, v[0]}, 32'h0);
  endtask
  task automatic fread(input logic [21:0] a, input logic [7:0] c, input logic [15:0] e);
    op(a, 16'h0000, c);
    rd(4'h4, v);
    check("rdata", v, {16'h0000, e});
  endtask
  task automatic stat(input int b, input logic e);
    rd(4'h3, v);
    check("status", {31'h0, v[b]}, {31'h0, e});
  endtask
  // main sequence
  initial begin
    rst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    errors = 0;
    checked = 0;
    cyc = 0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    rd(4'h3, v);
    check("status", v, 32'h0);
    rd(4'hF, v);
    check("unmapped", v, 32'h0);
    fread(22'h000010, 8'h01, 16'hFFEF);
    op(22'h000000, 16'h0000, 8'h23);
    stat(3, 1'b1);
    fread(22'h000005, 8'h01, 16'h0085);
    stat(4, 1'b1);
    op(22'h000000, 16'h0000, 8'h43);
    stat(3, 1'b0);
    fread(22'h000005, 8'h01, 16'hFFFA);
    fread(22'h000000, 8'h09, 16'h00A1);
    fread(22'h000001, 8'h09, 16'h00B2);
    fread(22'h020002, 8'h19, 16'h0001);
    fread(22'h030002, 8'h19, 16'h0000);
    // temporary unprotect is a level on the reset pin, no go needed
    wr(4'h1, 32'h00020000);
    wr(4'h0, 32'h4);
    repeat (3) @(posedge mclk);
    check("hv_reset", {31'h0, flash.hv_reset}, 32'h1);
    check("prot_gate", {31'h0, m.prot_hit}, 32'h0);
    stat(1, 1'b1);
    wr(4'h0, 32'h0);
    repeat (3) @(posedge mclk);
    check("hv_reset", {31'h0, flash.hv_reset}, 32'h0);
    check("prot_gate", {31'h0, m.prot_hit}, 32'h1);
    // a reset command keeps secured mode; a hardware reset leaves it
    op(22'h000000, 16'h0000, 8'h23);
    op(22'h000000, 16'h0000, 8'h63);
    stat(3, 1'b1);
    fread(22'h000005, 8'h01, 16'h0085);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    stat(3, 1'b0);
    fread(22'h000005, 8'h01, 16'hFFFA);
    // broken unlock pair must leave the flash in read mode
    op(22'h000555, 16'h00AA, 8'h03);
    op(22'h000123, 16'h0055, 8'h03);
    check("step", {30'h0, m.st}, 32'h0);
    check("secured", {31'h0, m.sec}, 32'h0);
    check("oe_write", m.bad, 32'h0);
    close_out();
  end
endmodule
